// File: hw/opc_clkout_div.sv
// Clock output divider that toggles a registered square wave.
`timescale 1ns/1ps
module opc_clkout_div
  import opc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [1:0] div_code_i,
  output logic clk_o
);

  typedef struct packed {
    logic [3:0] count;
    logic clk;
  } opc_div_st_t;

  opc_div_st_t st;
  opc_div_st_t next_st;
  logic [3:0] limit;

  always_comb begin
    unique case (div_code_i)
      2'b00: limit = OPC_DIV_BY1;
      2'b01: limit = OPC_DIV_BY2;
      2'b10: limit = OPC_DIV_BY4;
      2'b11: limit = OPC_DIV_BY10;
    endcase
  end

  // A shorter code takes effect at once because the count is compared with greater-or-equal.
  always_comb begin
    next_st = st;
    if (st.count + 4'h1 >= limit) begin
      next_st.count = 4'h0;
      next_st.clk = ~st.clk;
    end else begin
      next_st.count = st.count + 4'h1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st <= '{count: 4'h0, clk: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  assign clk_o = st.clk;

endmodule // opc_clkout_div

// File: hw/opc_osc_pin_ctrl.sv
// Oscillator, sleep and multipurpose pin control with its two byte-addressed registers.
`timescale 1ns/1ps

module opc_osc_pin_ctrl
  import opc_pkg::*;
(
  input wire logic CLK_SYS_I,
  input wire logic RST_I,
  input wire logic [11:0] REG_ADDR_I,
  input wire logic REG_WR_I,
  input wire logic REG_RD_I,
  input wire logic [7:0] REG_WDATA_I,
  output logic [7:0] REG_RDATA_O,
  output logic REG_RVALID_O,
  input wire logic CONFIG_MODE_I,
  input wire logic [2:0] OPERATING_MODE_REQUEST_I,
  input wire logic WAKEUP_IRQ_ENABLE_I,
  input wire opc_irq_t IRQ_SRC_I,
  input wire logic OSC_STABLE_I,
  input wire logic PLL_LOCK_I,
  input wire logic CHIP_SELECT_N_I,
  input wire logic CAN_RECEIVE_PIN_I,
  input wire logic CAN_TX_DATA_I,
  input wire logic SOF_I,
  input wire logic PIN_A_I,
  input wire logic PIN_B_I,
  output logic PIN_A_O,
  output logic PIN_A_OE_O,
  output logic PIN_B_O,
  output logic PIN_B_OE_O,
  output logic CAN_TRANSMIT_PIN_O,
  output logic CAN_TRANSMIT_PIN_OE_O,
  output logic CLOCK_OUTPUT_PIN_O,
  output logic TRANSCEIVER_STANDBY_O,
  output logic PLL_SELECT_O,
  output logic SYSCLK_HALVE_O,
  output logic CLOCK_STOP_O,
  output logic DEEP_SLEEP_STATE_O,
  output logic WAKE_TO_CONFIG_O
);

  typedef struct packed {
    opc_osc_t osc;
    opc_pin_t pin;
    opc_pwr_t pwr;
    logic [1:0] halve_pipe;
    logic rx_prev;
    logic cs_prev;
    logic [7:0] rdata;
    logic rvalid;
    logic [1:0] pin_o;
    logic [1:0] pin_oe;
    logic tx_o;
    logic tx_oe;
    logic clk_out;
    logic xstby;
    logic pll_sel_o;
    logic halve_o;
    logic stop_o;
    logic deep_o;
    logic wake_o;
  } opc_state_t;

  localparam opc_state_t ST_RST = '{
    osc: OPC_OSC_RST,
    pin: OPC_PIN_RST,
    pwr: OPC_RUN,
    halve_pipe: 2'h0,
    rx_prev: 1'b1,
    cs_prev: 1'b1,
    rdata: 8'h00,
    rvalid: 1'b0,
    pin_o: 2'h0,
    pin_oe: 2'h0,
    tx_o: 1'b1,
    tx_oe: 1'b0,
    clk_out: 1'b0,
    xstby: 1'b0,
    pll_sel_o: 1'b0,
    halve_o: 1'b0,
    stop_o: 1'b0,
    deep_o: 1'b0,
    wake_o: 1'b0
  };

  // Idle levels after reset: pins low, receive recessive, chip select released.
  localparam logic [OPC_SYNC_W-1:0] SYNC_RST = 6'h0c;

  opc_state_t st;
  opc_state_t next_st;
  logic [OPC_SYNC_W-1:0] sync_level;
  logic [1:0] pin_level;
  logic rx_level;
  logic cs_level;
  logic osc_ok;
  logic pll_lock;
  logic div_clk;
  logic [31:0] osc_word;
  logic [31:0] pin_word;
  logic [1:0] wr_sel;
  logic [1:0] rd_sel;
  logic sleep_req;
  logic rx_wake;
  logic cs_wake;

  // Returns a one-hot pick of the register a byte address falls in, or zero when unmapped.
  function automatic logic [1:0] reg_hit(input logic [11:0] addr);
    logic [1:0] hit;
    hit = 2'b00;
    if (addr[11:2] == OPC_OSC_ADDR[11:2]) begin
      hit = 2'b01;
    end else if (addr[11:2] == OPC_PIN_ADDR[11:2]) begin
      hit = 2'b10;
    end
    return hit;
  endfunction

  opc_pin_sync #(
    .W(OPC_SYNC_W)
  ) u_sync (
    .clk_i(CLK_SYS_I),
    .rst_i(RST_I),
    .async_i({PLL_LOCK_I, OSC_STABLE_I, CHIP_SELECT_N_I, CAN_RECEIVE_PIN_I, PIN_B_I, PIN_A_I}),
    .rst_level_i(SYNC_RST),
    .level_o(sync_level)
  );

  opc_clkout_div u_div (
    .clk_i(CLK_SYS_I),
    .rst_i(RST_I),
    .div_code_i(st.osc.out_div),
    .clk_o(div_clk)
  );

  assign pin_level = sync_level[1:0];
  assign rx_level = sync_level[2];
  assign cs_level = sync_level[3];
  assign osc_ok = sync_level[4];
  assign pll_lock = sync_level[5];

  assign wr_sel = REG_WR_I ? reg_hit(REG_ADDR_I) : 2'b00;
  assign rd_sel = reg_hit(REG_ADDR_I);

  // The request only counts in run; the select bit alone never starts a sleep.
  assign sleep_req = (OPERATING_MODE_REQUEST_I == OPC_REQ_SLEEP) && (st.pwr == OPC_RUN);
  assign rx_wake = st.rx_prev && !rx_level && WAKEUP_IRQ_ENABLE_I;
  assign cs_wake = st.cs_prev && !cs_level;

  always_comb begin
    osc_word = 32'h0;
    osc_word[OPC_OSC_SYNC_BIT] = st.halve_pipe[1];
    osc_word[OPC_OSC_STABLE_BIT] = osc_ok && (st.pwr == OPC_RUN);
    osc_word[OPC_OSC_PLL_BIT] = pll_lock;
    osc_word[OPC_OSC_OUTDIV_LSB +: 2] = st.osc.out_div;
    osc_word[OPC_OSC_HALVE_BIT] = st.osc.halve;
    osc_word[OPC_OSC_DEEP_BIT] = st.osc.deep_sel;
    osc_word[OPC_OSC_DIS_BIT] = st.osc.clk_dis;
    osc_word[OPC_OSC_PLLSEL_BIT] = st.osc.pll_sel;
  end

  always_comb begin
    pin_word = 32'h0;
    pin_word[OPC_PIN_IRQOD_BIT] = st.pin.od_irq;
    pin_word[OPC_PIN_SOF_BIT] = st.pin.sof_sel;
    pin_word[OPC_PIN_TXOD_BIT] = st.pin.od_tx;
    pin_word[OPC_PIN_FUNC_LSB +: 2] = st.pin.func;
    pin_word[OPC_PIN_LEVEL_LSB +: 2] = pin_level;
    pin_word[OPC_PIN_DRIVE_LSB +: 2] = st.pin.drive;
    pin_word[OPC_PIN_XSTBY_BIT] = st.pin.xstby_en;
    pin_word[OPC_PIN_DIR_LSB +: 2] = st.pin.dir;
  end

  always_comb begin
    logic [1:0] irq_req;
    logic [7:0] wd;
    irq_req = 2'b00;
    wd = REG_WDATA_I;
    next_st = st;
    next_st.wake_o = 1'b0;
    next_st.rx_prev = rx_level;
    next_st.cs_prev = cs_level;

    // Register reads answer one cycle later; unmapped addresses read zero.
    next_st.rvalid = REG_RD_I;
    if (REG_RD_I) begin
      unique case (rd_sel)
        2'b01: next_st.rdata = osc_word[{REG_ADDR_I[1:0], 3'b000} +: 8];
        2'b10: next_st.rdata = pin_word[{REG_ADDR_I[1:0], 3'b000} +: 8];
        default: next_st.rdata = 8'h00;
      endcase
    end

    // Writes land byte by byte, so a field never sees a half-written word.
    // The core is powered down in deep sleep and takes no writes there.
    if (st.pwr != OPC_DEEP) begin
      if (wr_sel == 2'b01 && REG_ADDR_I[1:0] == 2'b00) begin
        next_st.osc.out_div = wd[OPC_OSC_OUTDIV_LSB +: 2];
        next_st.osc.deep_sel = wd[OPC_OSC_DEEP_BIT];
        if (CONFIG_MODE_I) begin
          next_st.osc.halve = wd[OPC_OSC_HALVE_BIT];
          next_st.osc.pll_sel = wd[OPC_OSC_PLLSEL_BIT];
        end
        // A one written here is ignored; only hardware can set the disable flag.
        if (!wd[OPC_OSC_DIS_BIT]) begin
          next_st.osc.clk_dis = 1'b0;
          if (st.pwr == OPC_SLEEP) begin
            next_st.pwr = OPC_RUN;
            next_st.wake_o = 1'b1;
          end
        end
      end
      if (wr_sel == 2'b10) begin
        unique case (REG_ADDR_I[1:0])
          2'b11: begin
            next_st.pin.od_irq = wd[OPC_PIN_IRQOD_BIT - 24];
            next_st.pin.sof_sel = wd[OPC_PIN_SOF_BIT - 24];
            next_st.pin.od_tx = wd[OPC_PIN_TXOD_BIT - 24];
            next_st.pin.func = wd[OPC_PIN_FUNC_LSB - 24 +: 2];
          end
          2'b01: begin
            next_st.pin.drive = wd[OPC_PIN_DRIVE_LSB - 8 +: 2];
          end
          2'b00: begin
            next_st.pin.xstby_en = wd[OPC_PIN_XSTBY_BIT];
            next_st.pin.dir = wd[OPC_PIN_DIR_LSB +: 2];
          end
          default: begin
          end
        endcase
      end
    end

    // Wake and sleep sequencing; entry is placed last so that a set beats a clear.
    unique case (st.pwr)
      OPC_RUN: begin
        if (sleep_req) begin
          next_st.osc.clk_dis = 1'b1;
          next_st.pwr = st.osc.deep_sel ? OPC_DEEP : OPC_SLEEP;
        end
      end
      OPC_SLEEP: begin
        if (rx_wake) begin
          next_st.osc.clk_dis = 1'b0;
          next_st.pwr = OPC_RUN;
          next_st.wake_o = 1'b1;
        end
      end
      OPC_DEEP: begin
        // Contents are lost in deep sleep, so wake brings every field back to its reset value.
        if (rx_wake || cs_wake) begin
          next_st.osc = OPC_OSC_RST;
          next_st.pin = OPC_PIN_RST;
          next_st.pwr = OPC_RUN;
          next_st.wake_o = 1'b1;
        end
      end
      default: begin
        next_st.pwr = OPC_RUN;
      end
    endcase

    // The readback copy of the halve bit trails the control bit by two cycles.
    next_st.halve_pipe = {st.halve_pipe[0], st.osc.halve};

    // Clock source, sleep state, transceiver standby and clock output pin controls.
    next_st.pll_sel_o = st.osc.pll_sel;
    next_st.halve_o = st.osc.halve;
    next_st.stop_o = (st.pwr != OPC_RUN);
    next_st.deep_o = (st.pwr == OPC_DEEP);
    next_st.xstby = st.pin.xstby_en && (st.pwr != OPC_RUN);
    next_st.clk_out = st.pin.sof_sel ? SOF_I : div_clk;

    // Transmit pin: open-drain only pulls low and releases for recessive.
    if (st.pin.od_tx) begin
      next_st.tx_o = 1'b0;
      next_st.tx_oe = !CAN_TX_DATA_I;
    end else begin
      next_st.tx_o = CAN_TX_DATA_I;
      next_st.tx_oe = 1'b1;
    end

    // Multipurpose pins: interrupt outputs are active low.
    irq_req[0] = IRQ_SRC_I.tx_flag && IRQ_SRC_I.tx_en;
    irq_req[1] = IRQ_SRC_I.rx_flag && IRQ_SRC_I.rx_en;
    for (int i = 0; i < 2; i++) begin
      if (!st.pin.func[i]) begin
        // Direction is not looked at here; push-pull always drives, open-drain only while the request is set.
        if (st.pin.od_irq) begin
          next_st.pin_o[i] = 1'b0;
          next_st.pin_oe[i] = irq_req[i];
        end else begin
          next_st.pin_o[i] = !irq_req[i];
          next_st.pin_oe[i] = 1'b1;
        end
      end else if (!st.pin.dir[i]) begin
        next_st.pin_o[i] = st.pin.drive[i];
        next_st.pin_oe[i] = 1'b1;
      end else begin
        next_st.pin_o[i] = 1'b0;
        next_st.pin_oe[i] = 1'b0;
      end
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      st <= ST_RST;
    end else begin
      st <= next_st;
    end
  end

  assign REG_RDATA_O = st.rdata;
  assign REG_RVALID_O = st.rvalid;
  assign PIN_A_O = st.pin_o[0];
  assign PIN_A_OE_O = st.pin_oe[0];
  assign PIN_B_O = st.pin_o[1];
  assign PIN_B_OE_O = st.pin_oe[1];
  assign CAN_TRANSMIT_PIN_O = st.tx_o;
  assign CAN_TRANSMIT_PIN_OE_O = st.tx_oe;
  assign CLOCK_OUTPUT_PIN_O = st.clk_out;
  assign TRANSCEIVER_STANDBY_O = st.xstby;
  assign PLL_SELECT_O = st.pll_sel_o;
  assign SYSCLK_HALVE_O = st.halve_o;
  assign CLOCK_STOP_O = st.stop_o;
  assign DEEP_SLEEP_STATE_O = st.deep_o;
  assign WAKE_TO_CONFIG_O = st.wake_o;

endmodule // opc_osc_pin_ctrl

// File: hw/opc_pin_sync.sv
// Three-stage synchroniser whose output moves only when the last two stages agree.
`timescale 1ns/1ps
module opc_pin_sync
  import opc_pkg::*;
#(
  parameter int W = OPC_SYNC_W
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [W-1:0] async_i,
  input wire logic [W-1:0] rst_level_i,
  output logic [W-1:0] level_o
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] level;
  } opc_sync_st_t;

  opc_sync_st_t st;
  opc_sync_st_t next_st;

  // The first stage feeds only the second, so a metastable sample never reaches logic.
  always_comb begin
    next_st = st;
    next_st.s1 = async_i;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    for (int i = 0; i < W; i++) begin
      if (st.s2[i] == st.s3[i]) begin
        next_st.level[i] = st.s3[i];
      end
    end
  end

  // The reset level is a constant from the parent, so no port value is caught under reset.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st <= {rst_level_i, rst_level_i, rst_level_i, rst_level_i};
    end else begin
      st <= next_st;
    end
  end

  assign level_o = st.level;

endmodule // opc_pin_sync

// File: hw/opc_pkg.sv
// Package with offsets, field positions, reset values and types for the oscillator and pin control block.
package opc_pkg;

  localparam logic [11:0] OPC_OSC_ADDR = 12'h000;
  localparam logic [11:0] OPC_PIN_ADDR = 12'h004;

  localparam int OPC_OSC_SYNC_BIT = 12;
  localparam int OPC_OSC_STABLE_BIT = 10;
  localparam int OPC_OSC_PLL_BIT = 8;
  localparam int OPC_OSC_OUTDIV_LSB = 5;
  localparam int OPC_OSC_HALVE_BIT = 4;
  localparam int OPC_OSC_DEEP_BIT = 3;
  localparam int OPC_OSC_DIS_BIT = 2;
  localparam int OPC_OSC_PLLSEL_BIT = 0;

  localparam int OPC_PIN_IRQOD_BIT = 30;
  localparam int OPC_PIN_SOF_BIT = 29;
  localparam int OPC_PIN_TXOD_BIT = 28;
  localparam int OPC_PIN_FUNC_LSB = 24;
  localparam int OPC_PIN_LEVEL_LSB = 16;
  localparam int OPC_PIN_DRIVE_LSB = 8;
  localparam int OPC_PIN_XSTBY_BIT = 6;
  localparam int OPC_PIN_DIR_LSB = 0;

  localparam logic [1:0] OPC_OUTDIV_RST = 2'h3;
  localparam logic [1:0] OPC_FUNC_RST = 2'h3;
  localparam logic [1:0] OPC_DIR_RST = 2'h3;
  localparam logic [1:0] OPC_DRIVE_RST = 2'h0;

  localparam logic [3:0] OPC_DIV_BY1 = 4'h1;
  localparam logic [3:0] OPC_DIV_BY2 = 4'h2;
  localparam logic [3:0] OPC_DIV_BY4 = 4'h4;
  localparam logic [3:0] OPC_DIV_BY10 = 4'ha;

  localparam logic [2:0] OPC_REQ_SLEEP = 3'h1;
  localparam int OPC_SYNC_W = 6;

  typedef enum logic [1:0] {
    OPC_RUN = 2'b00,
    OPC_SLEEP = 2'b01,
    OPC_DEEP = 2'b10
  } opc_pwr_t;

  typedef struct packed {
    logic [1:0] out_div;
    logic halve;
    logic deep_sel;
    logic clk_dis;
    logic pll_sel;
  } opc_osc_t;

  typedef struct packed {
    logic od_irq;
    logic sof_sel;
    logic od_tx;
    logic [1:0] func;
    logic [1:0] drive;
    logic xstby_en;
    logic [1:0] dir;
  } opc_pin_t;

  typedef struct packed {
    logic tx_flag;
    logic tx_en;
    logic rx_flag;
    logic rx_en;
  } opc_irq_t;

  localparam opc_osc_t OPC_OSC_RST = '{out_div: OPC_OUTDIV_RST, halve: 1'b0, deep_sel: 1'b0,
                                      clk_dis: 1'b0, pll_sel: 1'b0};
  localparam opc_pin_t OPC_PIN_RST = '{od_irq: 1'b0, sof_sel: 1'b0, od_tx: 1'b0, func: OPC_FUNC_RST,
                                      drive: OPC_DRIVE_RST, xstby_en: 1'b0, dir: OPC_DIR_RST};

endpackage

// File: verification/opc_osc_pin_ctrl_asserts.sv
// Concurrent checks on the pin, clock output and sleep behaviour of the oscillator and pin control block.
`timescale 1ns/1ps
module opc_osc_pin_ctrl_asserts
  import opc_pkg::*;
(
  input wire logic CLK_SYS_I,
  input wire logic RST_I,
  input wire logic [11:0] REG_ADDR_I,
  input wire logic REG_WR_I,
  input wire logic [7:0] REG_WDATA_I,
  input wire logic CONFIG_MODE_I,
  input wire logic [2:0] OPERATING_MODE_REQUEST_I,
  input wire opc_irq_t IRQ_SRC_I,
  input wire logic CAN_TX_DATA_I,
  input wire logic SOF_I,
  input wire logic PIN_A_O,
  input wire logic PIN_A_OE_O,
  input wire logic PIN_B_O,
  input wire logic PIN_B_OE_O,
  input wire logic CAN_TRANSMIT_PIN_O,
  input wire logic CAN_TRANSMIT_PIN_OE_O,
  input wire logic CLOCK_OUTPUT_PIN_O,
  input wire logic PLL_SELECT_O,
  input wire logic SYSCLK_HALVE_O,
  input wire logic CLOCK_STOP_O,
  input wire logic DEEP_SLEEP_STATE_O,
  input wire logic WAKE_TO_CONFIG_O
);
  // Shadows of the written fields; pin checks wait until the settings are a few cycles old.
  logic [1:0] div_c;
  logic deep_c;
  logic [7:0] pin0;
  logic [7:0] pin1;
  logic [7:0] pin3;
  logic [4:0] quiet;
  logic [4:0] run;
  logic clk_out_q;
  logic irq_a;
  logic irq_b;
  logic [3:0] n_div;
  assign irq_a = IRQ_SRC_I.tx_flag & IRQ_SRC_I.tx_en;
  assign irq_b = IRQ_SRC_I.rx_flag & IRQ_SRC_I.rx_en;
  assign n_div = (div_c == 2'h0) ? OPC_DIV_BY1 : (div_c == 2'h1) ? OPC_DIV_BY2 :
                 (div_c == 2'h2) ? OPC_DIV_BY4 : OPC_DIV_BY10;
  always_ff @(posedge CLK_SYS_I) begin
    clk_out_q <= CLOCK_OUTPUT_PIN_O;
    run <= (CLOCK_OUTPUT_PIN_O != clk_out_q) ? 5'h00 : ((run == 5'h1f) ? run : run + 5'h01);
    quiet <= (RST_I || REG_WR_I || CLOCK_STOP_O || DEEP_SLEEP_STATE_O) ? 5'h00 :
             ((quiet == 5'h1f) ? quiet : quiet + 5'h01);
    if (RST_I || DEEP_SLEEP_STATE_O) begin
      div_c <= OPC_OUTDIV_RST;
      deep_c <= 1'b0;
      pin0 <= 8'h03;
      pin1 <= 8'h00;
      pin3 <= 8'h03;
    end else if (REG_WR_I) begin
      if (REG_ADDR_I == OPC_OSC_ADDR) begin
        div_c <= REG_WDATA_I[6:5];
        deep_c <= REG_WDATA_I[3];
      end
      if (REG_ADDR_I == OPC_PIN_ADDR) pin0 <= REG_WDATA_I;
      if (REG_ADDR_I == OPC_PIN_ADDR + 12'h001) pin1 <= REG_WDATA_I;
      if (REG_ADDR_I == OPC_PIN_ADDR + 12'h003) pin3 <= REG_WDATA_I;
    end
  end
  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (RST_I);
  AST_OUT_DIV: assert property ((quiet == 5'h1f && !pin3[5] && CLOCK_OUTPUT_PIN_O != clk_out_q) |->
    run == {1'b0, n_div - 4'h1}) else $error("clock output half period wrong");
  AST_SOF_PIN: assert property (quiet > 5'h02 && pin3[5] |-> CLOCK_OUTPUT_PIN_O == $past(SOF_I))
    else $error("clock output pin does not follow start of frame");
  AST_TX_PIN: assert property (quiet > 5'h02 |-> (pin3[4] ?
    (!CAN_TRANSMIT_PIN_O && CAN_TRANSMIT_PIN_OE_O == !$past(CAN_TX_DATA_I)) :
    (CAN_TRANSMIT_PIN_OE_O && CAN_TRANSMIT_PIN_O == $past(CAN_TX_DATA_I)))) else $error("transmit pin drive wrong");
  AST_PIN_A_IRQ: assert property (quiet > 5'h02 && !pin3[0] |-> (pin3[6] ?
    (!PIN_A_O && PIN_A_OE_O == $past(irq_a)) : (PIN_A_OE_O && PIN_A_O == !$past(irq_a))))
    else $error("pin A interrupt output wrong");
  AST_PIN_B_IRQ: assert property (quiet > 5'h02 && !pin3[1] |-> (pin3[6] ?
    (!PIN_B_O && PIN_B_OE_O == $past(irq_b)) : (PIN_B_OE_O && PIN_B_O == !$past(irq_b))))
    else $error("pin B interrupt output wrong");
  AST_PIN_A_GPIO: assert property (quiet > 5'h02 && pin3[0] |->
    PIN_A_OE_O == !pin0[0] && (pin0[0] || PIN_A_O == pin1[0])) else $error("pin A general purpose drive wrong");
  AST_PIN_B_GPIO: assert property (quiet > 5'h02 && pin3[1] |->
    PIN_B_OE_O == !pin0[1] && (pin0[1] || PIN_B_O == pin1[1])) else $error("pin B general purpose drive wrong");
  AST_HOLD_SEL: assert property ((!CONFIG_MODE_I && !DEEP_SLEEP_STATE_O) [*3] |=>
    $stable(PLL_SELECT_O) && $stable(SYSCLK_HALVE_O)) else $error("select bits changed outside configuration");
  AST_SLEEP_IN: assert property ((OPERATING_MODE_REQUEST_I == OPC_REQ_SLEEP &&
    $past(OPERATING_MODE_REQUEST_I) != OPC_REQ_SLEEP && !CLOCK_STOP_O && !REG_WR_I) |->
    ##2 (CLOCK_STOP_O && DEEP_SLEEP_STATE_O == deep_c)) else $error("sleep entry wrong");
  AST_WAKE_CLR: assert property ((CLOCK_STOP_O && !DEEP_SLEEP_STATE_O && REG_WR_I &&
    REG_ADDR_I == OPC_OSC_ADDR && !REG_WDATA_I[2]) |=> WAKE_TO_CONFIG_O ##1 !CLOCK_STOP_O)
    else $error("clearing clock disable did not wake");
endmodule // opc_osc_pin_ctrl_asserts

// File: verification/opc_pin_world.sv
// Board model of the two multipurpose pins with pull-ups and an outside driver.
`timescale 1ns/1ps
module opc_pin_world (
  input wire logic a_o_i,
  input wire logic a_oe_i,
  input wire logic b_o_i,
  input wire logic b_oe_i,
  input wire logic ext_en_i,
  input wire logic ext_a_i,
  input wire logic ext_b_i,
  output logic a_lvl_o,
  output logic b_lvl_o
);
  // Released or open-drain pins rest high through the pull-ups unless the outside driver is enabled, so no stale level is seen.
  assign a_lvl_o = a_oe_i ? a_o_i : (ext_en_i ? ext_a_i : 1'b1);
  assign b_lvl_o = b_oe_i ? b_o_i : (ext_en_i ? ext_b_i : 1'b1);
endmodule // opc_pin_world

// File: verification/tb.sv
// Self-checking bench for the oscillator and pin control block.
`timescale 1ns/1ps
module tb;
  import opc_pkg::*;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [11:0] addr = 12'h000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] wdata = 8'h00;
  logic [7:0] rdata;
  logic rvalid;
  logic cfg = 1'b0;
  logic [2:0] req = 3'h0;
  logic wake_en = 1'b0;
  opc_irq_t irq = 4'h0;
  logic osc_ok = 1'b1;
  logic pll_ok = 1'b1;
  logic cs_n = 1'b1;
  logic rx = 1'b1;
  logic tx_d = 1'b1;
  logic sof = 1'b0;
  logic ext_en = 1'b0;
  logic ext_a = 1'b0;
  logic ext_b = 1'b0;
  logic lvl_a, lvl_b, pa_o, pa_oe, pb_o, pb_oe, tx_o, tx_oe, clk_out, stby, pll_sel, halve, stop, deep, wake;
  int mismatches = 0;
  int total_checks = 0;
  int cyc = 0;
  logic [7:0] n;
  logic last;
  logic [3:0] dv [4] = '{OPC_DIV_BY1, OPC_DIV_BY2, OPC_DIV_BY4, OPC_DIV_BY10};
  always #20 clk_sys = ~clk_sys;
  opc_osc_pin_ctrl opc_osc_pin_ctrl_inst (.CLK_SYS_I(clk_sys), .RST_I(rst), .REG_ADDR_I(addr), .REG_WR_I(wr),
    .REG_RD_I(rd), .REG_WDATA_I(wdata), .REG_RDATA_O(rdata), .REG_RVALID_O(rvalid), .CONFIG_MODE_I(cfg),
    .OPERATING_MODE_REQUEST_I(req), .WAKEUP_IRQ_ENABLE_I(wake_en), .IRQ_SRC_I(irq), .OSC_STABLE_I(osc_ok),
    .PLL_LOCK_I(pll_ok), .CHIP_SELECT_N_I(cs_n), .CAN_RECEIVE_PIN_I(rx), .CAN_TX_DATA_I(tx_d), .SOF_I(sof),
    .PIN_A_I(lvl_a), .PIN_B_I(lvl_b), .PIN_A_O(pa_o), .PIN_A_OE_O(pa_oe), .PIN_B_O(pb_o), .PIN_B_OE_O(pb_oe),
    .CAN_TRANSMIT_PIN_O(tx_o), .CAN_TRANSMIT_PIN_OE_O(tx_oe), .CLOCK_OUTPUT_PIN_O(clk_out),
    .TRANSCEIVER_STANDBY_O(stby), .PLL_SELECT_O(pll_sel), .SYSCLK_HALVE_O(halve), .CLOCK_STOP_O(stop),
    .DEEP_SLEEP_STATE_O(deep), .WAKE_TO_CONFIG_O(wake));
  opc_pin_world opc_pin_world_inst (.a_o_i(pa_o), .a_oe_i(pa_oe), .b_o_i(pb_o), .b_oe_i(pb_oe),
    .ext_en_i(ext_en), .ext_a_i(ext_a), .ext_b_i(ext_b), .a_lvl_o(lvl_a), .b_lvl_o(lvl_b));
  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic idle(input int k);
    repeat (k) @(negedge clk_sys);
  endtask
  // Every write carries one byte, so pin fields are never written in a wider burst.
  task automatic wr_b(input logic [11:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge clk_sys);
    wr = 1'b0;
  endtask
  task automatic rd_chk(input logic [11:0] a, input logic [7:0] exp);
    @(negedge clk_sys);
    addr = a;
    rd = 1'b1;
    @(negedge clk_sys);
    rd = 1'b0;
    chk((rvalid === 1'b1) ? rdata : 8'hee, exp);
  endtask
  // The transmit bit and start of frame move on a fixed pattern; the cycle count also cuts a hang short.
  always @(negedge clk_sys) begin
    cyc++;
    tx_d <= cyc[0] ^ cyc[2];
    sof <= cyc[3];
    if (cyc > 4000) begin
      mismatches++;
      conclude();
    end
  end
  initial begin
    idle(2);
    rst = 1'b0;
    idle(4);
    rd_chk(OPC_OSC_ADDR, 8'h60);
    rd_chk(OPC_OSC_ADDR + 12'h001, 8'h05);
    rd_chk(OPC_OSC_ADDR + 12'h003, 8'h00);
    rd_chk(OPC_PIN_ADDR, 8'h03);
    rd_chk(OPC_PIN_ADDR + 12'h002, 8'h03);
    rd_chk(OPC_PIN_ADDR + 12'h003, 8'h03);
    rd_chk(12'h008, 8'h00);
    $display("reset values done");
    cfg = 1'b1;
    wr_b(OPC_OSC_ADDR, 8'h71);
    cfg = 1'b0;
    idle(4);
    chk({6'h00, pll_sel, halve}, 8'h03);
    rd_chk(OPC_OSC_ADDR + 12'h001, 8'h15);
    wr_b(OPC_OSC_ADDR, 8'h04);
    wr_b(OPC_OSC_ADDR + 12'h001, 8'hff);
    pll_ok = 1'b0;
    idle(5);
    rd_chk(OPC_OSC_ADDR, 8'h11);
    rd_chk(OPC_OSC_ADDR + 12'h001, 8'h14);
    osc_ok = 1'b0;
    pll_ok = 1'b1;
    idle(5);
    rd_chk(OPC_OSC_ADDR + 12'h001, 8'h11);
    osc_ok = 1'b1;
    $display("clock selection done");
    for (int i = 0; i < 4; i++) begin
      wr_b(OPC_OSC_ADDR, {1'b0, i[1:0], 5'h11});
      idle(40);
      n = 8'h00;
      last = clk_out;
      repeat (40) begin
        @(negedge clk_sys);
        if (clk_out !== last) n++;
        last = clk_out;
      end
      chk(n, 8'(40 / dv[i]));
    end
    $display("clock output done");
    irq = 4'hd;
    wr_b(OPC_PIN_ADDR + 12'h003, 8'h00);
    idle(5);
    chk({7'h00, pa_oe}, 8'h01);
    rd_chk(OPC_PIN_ADDR + 12'h002, 8'h02);
    wr_b(OPC_PIN_ADDR + 12'h003, 8'h40);
    idle(5);
    chk({5'h00, pa_oe, pa_o, pb_oe}, 8'h04);
    wr_b(OPC_PIN_ADDR + 12'h003, 8'h03);
    wr_b(OPC_PIN_ADDR + 12'h001, 8'h02);
    wr_b(OPC_PIN_ADDR, 8'h40);
    idle(5);
    rd_chk(OPC_PIN_ADDR + 12'h002, 8'h02);
    wr_b(OPC_PIN_ADDR, 8'h43);
    ext_en = 1'b1;
    ext_a = 1'b1;
    idle(6);
    rd_chk(OPC_PIN_ADDR + 12'h002, 8'h01);
    ext_en = 1'b0;
    wr_b(OPC_PIN_ADDR + 12'h003, 8'h33);
    idle(30);
    wr_b(OPC_PIN_ADDR + 12'h003, 8'h03);
    $display("pin control done");
    req = OPC_REQ_SLEEP;
    idle(3);
    req = 3'h0;
    chk({5'h00, stop, deep, stby}, 8'h05);
    rd_chk(OPC_OSC_ADDR, 8'h75);
    rd_chk(OPC_OSC_ADDR + 12'h001, 8'h11);
    wr_b(OPC_OSC_ADDR, 8'h71);
    idle(3);
    chk({7'h00, stop}, 8'h00);
    rd_chk(OPC_OSC_ADDR, 8'h71);
    wake_en = 1'b1;
    req = OPC_REQ_SLEEP;
    idle(3);
    req = 3'h0;
    rx = 1'b0;
    idle(8);
    rx = 1'b1;
    chk({7'h00, stop}, 8'h00);
    wr_b(OPC_OSC_ADDR, 8'h79);
    idle(2);
    chk({7'h00, stop}, 8'h00);
    req = OPC_REQ_SLEEP;
    idle(3);
    req = 3'h0;
    chk({6'h00, stop, deep}, 8'h03);
    cs_n = 1'b0;
    idle(8);
    cs_n = 1'b1;
    idle(4);
    chk({7'h00, deep}, 8'h00);
    rd_chk(OPC_OSC_ADDR, 8'h60);
    rd_chk(OPC_PIN_ADDR + 12'h003, 8'h03);
    $display("sleep done");
    conclude();
  end
endmodule // tb
bind opc_osc_pin_ctrl opc_osc_pin_ctrl_asserts opc_osc_pin_ctrl_asserts_inst (.CLK_SYS_I(CLK_SYS_I), .RST_I(RST_I),
  .REG_ADDR_I(REG_ADDR_I), .REG_WR_I(REG_WR_I), .REG_WDATA_I(REG_WDATA_I), .CONFIG_MODE_I(CONFIG_MODE_I),
  .OPERATING_MODE_REQUEST_I(OPERATING_MODE_REQUEST_I), .IRQ_SRC_I(IRQ_SRC_I), .CAN_TX_DATA_I(CAN_TX_DATA_I),
  .SOF_I(SOF_I), .PIN_A_O(PIN_A_O), .PIN_A_OE_O(PIN_A_OE_O), .PIN_B_O(PIN_B_O), .PIN_B_OE_O(PIN_B_OE_O),
  .CAN_TRANSMIT_PIN_O(CAN_TRANSMIT_PIN_O), .CAN_TRANSMIT_PIN_OE_O(CAN_TRANSMIT_PIN_OE_O),
  .CLOCK_OUTPUT_PIN_O(CLOCK_OUTPUT_PIN_O), .PLL_SELECT_O(PLL_SELECT_O), .SYSCLK_HALVE_O(SYSCLK_HALVE_O),
  .CLOCK_STOP_O(CLOCK_STOP_O), .DEEP_SLEEP_STATE_O(DEEP_SLEEP_STATE_O), .WAKE_TO_CONFIG_O(WAKE_TO_CONFIG_O));
